// ### design/cssw_pkg.sv
package cssw_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 100;
  localparam int HIGH_SETTLE_US  = 65;
  localparam int HIGH_SETTLE_CYC = HIGH_SETTLE_US * CLK_MHZ;
  localparam int LOW_SETTLE_US   = 210;
  localparam int LOW_SETTLE_CYC  = LOW_SETTLE_US * CLK_MHZ;
  localparam int POLL_LIMIT_DEF  = 1000;
  localparam int TMR_W           = 15;
  localparam int POLL_W          = 10;
  // ----------------------------------------------------------------
  // Device register indices and fields
  // ----------------------------------------------------------------
  localparam logic [2:0] DEV_RUN    = 3'h0;
  localparam logic [2:0] DEV_SYS    = 3'h1;
  localparam logic [2:0] DEV_SUBSRC = 3'h2;
  localparam logic [2:0] DEV_MODE   = 3'h3;
  localparam logic [2:0] DEV_STSEL  = 3'h4;
  localparam logic [2:0] DEV_STCNT  = 3'h5;
  localparam int RUN_HIGH_STOP = 0;
  localparam int RUN_MID_EN    = 1;
  localparam int RUN_MAIN_STOP = 7;
  localparam int SYS_OSC_SEL   = 0;
  localparam int SYS_OSC_STAT  = 1;
  localparam int SYS_MAIN_SEL  = 4;
  localparam int SYS_MAIN_STAT = 5;
  localparam int SYS_SUB_SEL   = 6;
  localparam int SYS_SUB_STAT  = 7;
  localparam int MODE_GAIN     = 0;
  localparam int MODE_OSC_EN   = 6;
  localparam int MODE_EXT      = 7;
  localparam logic [7:0] SUBSRC_LOW_ON = 8'h01;
  localparam logic [7:0] STCNT_OK_MASK = 8'hE0;
  localparam logic [7:0] RUN_RESET     = 8'hC3;
  localparam logic [7:0] SYS_RESET     = 8'h01;
  // ----------------------------------------------------------------
  // Host registers
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_CMD     = 2'h0;
  localparam logic [1:0] REG_STATUS  = 2'h1;
  localparam logic [1:0] REG_DEVSTAT = 2'h2;
  localparam int CMD_TGT_LSB  = 0;
  localparam int CMD_SKIP_LOW = 2;
  localparam int CMD_GAIN     = 3;
  localparam int CMD_SEL_LSB  = 4;
  localparam int CMD_GO       = 7;
  localparam int STAT_DONE    = 1;
  localparam int STAT_ERR     = 2;
  localparam logic [1:0] TGT_HIGH = 2'h0;
  localparam logic [1:0] TGT_LOW  = 2'h1;
  localparam logic [1:0] TGT_XTAL = 2'h2;
  localparam logic [1:0] TGT_EXT  = 2'h3;
  localparam logic [2:0] SRC_MIDDLE = 3'h0;
  localparam logic [2:0] SRC_STEP   = 3'h1;

  typedef enum logic [3:0] {
    ST_IDLE, ST_W_MODE, ST_W_STSEL, ST_WAIT_EXT, ST_W_RUN_ON, ST_W_SUBSRC,
    ST_SETTLE, ST_POLL_STCNT, ST_W_SYS, ST_POLL_SYS, ST_W_RUN_OFF
  } cssw_state_t;
endpackage

// ### design/cssw_dev_if.sv
`timescale 1ns/1ns
`default_nettype none
interface cssw_dev_if;
  logic       req_wr;
  logic       req_rd;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       done;
  modport master (output req_wr, req_rd, addr, wdata, input rdata, done);
  modport port   (input req_wr, req_rd, addr, wdata, output rdata, done);
endinterface
`default_nettype wire

// ### design/cssw_wait_timer.sv
`timescale 1ns/1ns
`default_nettype none
module cssw_wait_timer #(
  parameter int W = 15
) (
  // Clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_nrst,
  input  wire logic         i_ce,
  // Control
  input  wire logic         i_load,
  input  wire logic [W-1:0] i_count,
  output logic              o_done
);
  import cssw_pkg::*;
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } cssw_tmr_t;
  cssw_tmr_t r_reg;
  cssw_tmr_t r_next;

  // ----------------------------------------------------------------
  // Down counter, one-cycle done after i_count cycles
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (i_load) begin
      r_next.cnt = i_count;
    end else if (r_reg.cnt != '0) begin
      r_next.cnt = r_reg.cnt - 1'b1;
      r_next.done = (r_reg.cnt == W'(1));
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg <= '0;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  assign o_done = r_reg.done;
endmodule
`default_nettype wire

// ### design/cssw_dev_port.sv
`timescale 1ns/1ns
`default_nettype none
module cssw_dev_port (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_ce,
  // Request side
  cssw_dev_if.port        dev,
  // Device register pins
  output logic [2:0]      o_dev_addr,
  output logic [7:0]      o_dev_wdata,
  output logic            o_dev_wr,
  output logic            o_dev_rd,
  input  wire logic [7:0] i_dev_rdata
);
  import cssw_pkg::*;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       rd_pend;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       done;
    logic [7:0] rdata;
  } cssw_port_t;
  cssw_port_t r_reg;
  cssw_port_t r_next;

  // ----------------------------------------------------------------
  // Strobe one cycle after request, read data one cycle after strobe
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.wr = 1'b0;
    r_next.rd = 1'b0;
    r_next.done = r_reg.wr;
    r_next.rd_pend = r_reg.rd;
    if (r_reg.rd_pend) begin
      r_next.rdata = i_dev_rdata;
      r_next.done = 1'b1;
    end
    if (dev.req_wr || dev.req_rd) begin
      r_next.wr = dev.req_wr;
      r_next.rd = dev.req_rd;
      r_next.addr = dev.addr;
      r_next.wdata = dev.wdata;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg <= '0;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  assign o_dev_addr  = r_reg.addr;
  assign o_dev_wdata = r_reg.wdata;
  assign o_dev_wr    = r_reg.wr;
  assign o_dev_rd    = r_reg.rd;
  assign dev.done    = r_reg.done;
  assign dev.rdata   = r_reg.rdata;
endmodule
`default_nettype wire

// ### design/cssw_host.sv
// The strobed register port and the address map were decided locally.
`timescale 1ns/1ns
`default_nettype none
module cssw_host #(
  parameter int unsigned HIGH_SETTLE_CYC = cssw_pkg::HIGH_SETTLE_CYC,
  parameter int unsigned LOW_SETTLE_CYC  = cssw_pkg::LOW_SETTLE_CYC,
  parameter int unsigned POLL_LIMIT      = cssw_pkg::POLL_LIMIT_DEF
) (
  // Clock, reset, enable
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_ce,
  // Host register port
  input  wire logic [1:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic [7:0]      o_rdata,
  // Device register pins
  output logic [2:0]      o_dev_addr,
  output logic [7:0]      o_dev_wdata,
  output logic            o_dev_wr,
  output logic            o_dev_rd,
  input  wire logic [7:0] i_dev_rdata,
  // External clock presence pin
  input  wire logic       i_ext_clk_applied
);
  import cssw_pkg::*;

  typedef struct packed {
    cssw_state_t       st;
    logic              sent;
    logic [1:0]        tgt;
    logic              skip_low;
    logic              gain;
    logic [2:0]        sel;
    logic [7:0]        run;
    logic [7:0]        sys;
    logic [7:0]        dstat;
    logic              settled;
    logic              osc_ok;
    logic              confirmed;
    logic              done;
    logic              err;
    logic [2:0]        src;
    logic [POLL_W-1:0] polls;
    logic [7:0]        rdata;
    logic [1:0]        ext_sync;
  } cssw_main_t;

  cssw_main_t r_reg;
  cssw_main_t r_next;
  cssw_dev_if dev ();
  logic             tmr_load;
  logic [TMR_W-1:0] tmr_count;
  logic             tmr_done;
  logic             acc_wr;
  logic             acc_rd;
  logic [2:0]       acc_addr;
  logic [7:0]       acc_data;
  logic             step;
  logic             stat_ok;
  logic             ext_ok;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  cssw_wait_timer #(
    .W       (TMR_W)
  ) u_timer (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_ce    (i_ce),
    .i_load  (tmr_load),
    .i_count (tmr_count),
    .o_done  (tmr_done)
  );

  cssw_dev_port u_port (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_ce        (i_ce),
    .dev         (dev),
    .o_dev_addr  (o_dev_addr),
    .o_dev_wdata (o_dev_wdata),
    .o_dev_wr    (o_dev_wr),
    .o_dev_rd    (o_dev_rd),
    .i_dev_rdata (i_dev_rdata)
  );

  assign ext_ok = r_reg.ext_sync[1];
  assign tmr_count = (r_reg.tgt == TGT_HIGH) ? TMR_W'(HIGH_SETTLE_CYC)
                                             : TMR_W'(LOW_SETTLE_CYC);

  // ----------------------------------------------------------------
  // Device access chosen by state
  // ----------------------------------------------------------------
  always_comb begin
    acc_wr = 1'b0;
    acc_rd = 1'b0;
    acc_addr = DEV_RUN;
    acc_data = 8'h00;
    case (r_reg.st)
      ST_W_MODE: begin
        acc_wr = 1'b1;
        acc_addr = DEV_MODE;
        acc_data[MODE_OSC_EN] = 1'b1;
        acc_data[MODE_GAIN] = r_reg.gain;
        acc_data[MODE_EXT] = (r_reg.tgt == TGT_EXT);
      end
      ST_W_STSEL: begin
        acc_wr = 1'b1;
        acc_addr = DEV_STSEL;
        acc_data = {5'h00, r_reg.sel};
      end
      ST_W_RUN_ON: begin
        acc_wr = 1'b1;
        acc_data = r_reg.run;
        if (r_reg.tgt == TGT_HIGH) begin
          acc_data[RUN_HIGH_STOP] = 1'b0;
        end else begin
          acc_data[RUN_MAIN_STOP] = 1'b0;
        end
      end
      ST_W_SUBSRC: begin
        acc_wr = 1'b1;
        acc_addr = DEV_SUBSRC;
        acc_data = SUBSRC_LOW_ON;
      end
      ST_POLL_STCNT: begin
        acc_rd = 1'b1;
        acc_addr = DEV_STCNT;
      end
      ST_W_SYS: begin
        acc_wr = 1'b1;
        acc_addr = DEV_SYS;
        acc_data = r_reg.sys;
        case (r_reg.tgt)
          TGT_HIGH: acc_data[SYS_OSC_SEL] = 1'b0;
          TGT_LOW:  acc_data[SYS_SUB_SEL] = 1'b1;
          default:  acc_data[SYS_MAIN_SEL] = 1'b1;
        endcase
      end
      ST_POLL_SYS: begin
        acc_rd = 1'b1;
        acc_addr = DEV_SYS;
      end
      ST_W_RUN_OFF: begin
        acc_wr = 1'b1;
        acc_data = r_reg.run;
        acc_data[RUN_MID_EN] = 1'b0;
      end
      default: begin
        acc_wr = 1'b0;
      end
    endcase
  end

  // Switch confirmed only once the device status follows the target
  always_comb begin
    case (r_reg.tgt)
      TGT_HIGH: stat_ok = !dev.rdata[SYS_OSC_STAT];
      TGT_LOW:  stat_ok = dev.rdata[SYS_SUB_STAT];
      default:  stat_ok = dev.rdata[SYS_MAIN_STAT];
    endcase
  end

  assign dev.req_wr = acc_wr && !r_reg.sent;
  assign dev.req_rd = acc_rd && !r_reg.sent;
  assign dev.addr   = acc_addr;
  assign dev.wdata  = acc_data;
  assign step       = r_reg.sent && dev.done;

  // ----------------------------------------------------------------
  // Sequencer and host registers
  // ----------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    tmr_load = 1'b0;
    r_next.ext_sync = {r_reg.ext_sync[0], i_ext_clk_applied};
    if (dev.req_wr || dev.req_rd) begin
      r_next.sent = 1'b1;
    end
    if (step) begin
      r_next.sent = 1'b0;
      if (acc_wr) begin
        if (acc_addr == DEV_RUN) begin
          r_next.run = acc_data;
        end
        if (acc_addr == DEV_SYS) begin
          r_next.sys = acc_data;
        end
      end
    end
    // Host writes; hardware sets below override these clears
    if (i_wr && (i_addr == REG_STATUS)) begin
      if (i_wdata[STAT_DONE]) begin
        r_next.done = 1'b0;
      end
      if (i_wdata[STAT_ERR]) begin
        r_next.err = 1'b0;
      end
    end
    if (i_wr && (i_addr == REG_CMD) && i_wdata[CMD_GO]) begin
      if ((r_reg.st == ST_IDLE) && (r_reg.src == SRC_MIDDLE)) begin
        r_next.tgt = i_wdata[CMD_TGT_LSB +: 2];
        r_next.skip_low = i_wdata[CMD_SKIP_LOW];
        r_next.gain = i_wdata[CMD_GAIN];
        r_next.sel = i_wdata[CMD_SEL_LSB +: 3];
        r_next.settled = 1'b0;
        r_next.osc_ok = 1'b0;
        r_next.confirmed = 1'b0;
        r_next.polls = '0;
        case (i_wdata[CMD_TGT_LSB +: 2])
          TGT_HIGH: r_next.st = ST_W_RUN_ON;
          TGT_LOW:  r_next.st = ST_W_SUBSRC;
          default:  r_next.st = ST_W_MODE;
        endcase
      end else begin
        r_next.err = 1'b1;
      end
    end
    case (r_reg.st)
      ST_IDLE: begin
        r_next.sent = 1'b0;
      end
      ST_W_MODE: begin
        if (step) begin
          r_next.st = (r_reg.tgt == TGT_EXT) ? ST_WAIT_EXT : ST_W_STSEL;
        end
      end
      ST_W_STSEL: begin
        if (step) begin
          r_next.st = ST_W_RUN_ON;
        end
      end
      ST_WAIT_EXT: begin
        if (ext_ok) begin
          r_next.st = ST_W_RUN_ON;
        end
      end
      ST_W_RUN_ON: begin
        if (step) begin
          case (r_reg.tgt)
            TGT_HIGH: begin
              tmr_load = 1'b1;
              r_next.st = ST_SETTLE;
            end
            TGT_XTAL: r_next.st = ST_POLL_STCNT;
            default: begin
              r_next.osc_ok = 1'b1;
              r_next.st = ST_W_SYS;
            end
          endcase
        end
      end
      ST_W_SUBSRC: begin
        if (step) begin
          if (r_reg.skip_low) begin
            r_next.settled = 1'b1;
            r_next.st = ST_W_SYS;
          end else begin
            tmr_load = 1'b1;
            r_next.st = ST_SETTLE;
          end
        end
      end
      ST_SETTLE: begin
        if (tmr_done) begin
          r_next.settled = 1'b1;
          r_next.st = ST_W_SYS;
        end
      end
      ST_POLL_STCNT: begin
        if (step) begin
          if ((dev.rdata & STCNT_OK_MASK) == STCNT_OK_MASK) begin
            r_next.osc_ok = 1'b1;
            r_next.polls = '0;
            r_next.st = ST_W_SYS;
          end else if (r_reg.polls == POLL_W'(POLL_LIMIT)) begin
            r_next.err = 1'b1;
            r_next.st = ST_IDLE;
          end else begin
            r_next.polls = r_reg.polls + 1'b1;
          end
        end
      end
      ST_W_SYS: begin
        if (step) begin
          r_next.st = ST_POLL_SYS;
        end
      end
      ST_POLL_SYS: begin
        if (step) begin
          r_next.dstat = dev.rdata;
          if (stat_ok) begin
            r_next.confirmed = 1'b1;
            r_next.st = ST_W_RUN_OFF;
          end else if (r_reg.polls == POLL_W'(POLL_LIMIT)) begin
            r_next.err = 1'b1;
            r_next.st = ST_IDLE;
          end else begin
            r_next.polls = r_reg.polls + 1'b1;
          end
        end
      end
      ST_W_RUN_OFF: begin
        if (step) begin
          r_next.done = 1'b1;
          r_next.src = 3'({1'b0, r_reg.tgt}) + SRC_STEP;
          r_next.st = ST_IDLE;
        end
      end
      default: begin
        r_next.st = ST_IDLE;
      end
    endcase
    r_next.rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        REG_CMD:     r_next.rdata = {1'b0, r_reg.sel, r_reg.gain,
                                     r_reg.skip_low, r_reg.tgt};
        REG_STATUS:  r_next.rdata = {1'b0, r_reg.src, 1'b0, r_reg.err,
                                     r_reg.done, (r_reg.st != ST_IDLE)};
        REG_DEVSTAT: r_next.rdata = r_reg.dstat;
        default:     r_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      r_reg <= '0;
      r_reg.st <= ST_IDLE;
      r_reg.run <= RUN_RESET;
      r_reg.sys <= SYS_RESET;
      r_reg.src <= SRC_MIDDLE;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  assign o_rdata = r_reg.rdata;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  a_high_settle: assert property (
    (dev.req_wr && dev.addr == DEV_SYS && r_reg.tgt == TGT_HIGH)
      |-> r_reg.settled && !dev.wdata[SYS_OSC_SEL])
    else $error("high oscillator selected before settling");
  a_onchip_stat: assert property (
    (dev.req_wr && dev.addr == DEV_RUN && !dev.wdata[RUN_MID_EN]
      && r_reg.tgt == TGT_HIGH) |-> !r_reg.dstat[SYS_OSC_STAT])
    else $error("middle stopped while on-chip status not 0");
  a_mid_stop_order: assert property (
    (dev.req_wr && dev.addr == DEV_RUN && !dev.wdata[RUN_MID_EN])
      |-> r_reg.confirmed && (r_reg.settled || r_reg.osc_ok))
    else $error("middle stopped before switch confirmed");
  a_low_settle: assert property (
    (dev.req_wr && dev.addr == DEV_SYS && r_reg.tgt == TGT_LOW)
      |-> r_reg.settled && dev.wdata[SYS_SUB_SEL])
    else $error("subclock selected before low settling");
  a_sub_stat: assert property (
    (dev.req_wr && dev.addr == DEV_RUN && !dev.wdata[RUN_MID_EN]
      && r_reg.tgt == TGT_LOW) |-> r_reg.dstat[SYS_SUB_STAT])
    else $error("middle stopped while subclock status not 1");
  a_gain_bit: assert property (
    (dev.req_wr && dev.addr == DEV_MODE)
      |-> dev.wdata[MODE_OSC_EN] && dev.wdata[MODE_GAIN] == r_reg.gain)
    else $error("clock mode write lacks enable or gain");
  a_ext_bits: assert property (
    (dev.req_wr && dev.addr == DEV_MODE)
      |-> dev.wdata[MODE_EXT] == (r_reg.tgt == TGT_EXT))
    else $error("external clock bit wrong");
  a_stsel_value: assert property (
    (dev.req_wr && dev.addr == DEV_STSEL)
      |-> r_reg.tgt == TGT_XTAL && dev.wdata == {5'h00, r_reg.sel})
    else $error("settle select write wrong");
  a_ext_applied: assert property (
    (dev.req_wr && dev.addr == DEV_RUN && !dev.wdata[RUN_MAIN_STOP]
      && r_reg.tgt == TGT_EXT) |-> ext_ok)
    else $error("main stop cleared before external clock");
  a_osc_stable: assert property (
    (dev.req_wr && dev.addr == DEV_SYS && r_reg.tgt == TGT_XTAL)
      |-> r_reg.osc_ok)
    else $error("crystal selected before counter settled");
  a_main_stat: assert property (
    (r_reg.st == ST_POLL_SYS && step && r_reg.tgt[1]
      && !dev.rdata[SYS_MAIN_STAT] && i_ce) |=> r_reg.st == ST_POLL_SYS
      || r_reg.st == ST_IDLE)
    else $error("main status 0 yet sequence advanced");
  a_read_slot: assert property (
    (dev.req_rd && i_ce) ##1 i_ce ##1 i_ce |=> dev.done)
    else $error("device read answer not in time");

  c_to_high: cover property (r_reg.st == ST_W_RUN_OFF && step
                             && r_reg.tgt == TGT_HIGH);
  c_to_low:  cover property (r_reg.st == ST_W_RUN_OFF && step
                             && r_reg.tgt == TGT_LOW);
  c_to_xtal: cover property (r_reg.st == ST_W_RUN_OFF && step
                             && r_reg.tgt == TGT_XTAL);
  c_to_ext:  cover property (r_reg.st == ST_W_RUN_OFF && step
                             && r_reg.tgt == TGT_EXT);
endmodule
`default_nettype wire

// ### tb/cssw_dev_model.sv
`timescale 1ns/1ns
`default_nettype none
module cssw_dev_model #(
  parameter int GAP = 5
) (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  // Register pins
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic       i_ext,
  output logic [7:0]      o_rdata
);
  // --------
  // Device
  // --------
  logic [7:0]  regs [6];
  logic [1:0]  dly;
  logic [15:0] gap;
  logic        bad;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      regs <= '{8'hC3, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
      dly <= 2'h0;
      gap <= 16'h0;
      bad <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      gap <= gap + 16'h1;
      // Released bus shows a changing pattern
      o_rdata <= ~o_rdata;
      if (dly != 2'h0) dly <= dly - 2'h1;
      if (dly == 2'h1) begin
        regs[1][7] <= regs[1][6];
        regs[1][5] <= regs[1][4];
        regs[1][1] <= regs[1][0];
      end
      if (!regs[0][7] && gap[1:0] == 2'h3) begin
        regs[5] <= {1'b1, regs[5][7:1]};
      end
      if (i_rd) o_rdata <= regs[i_addr];
      if (i_wr && i_addr == 3'h1) begin
        regs[1][6] <= i_wdata[6];
        regs[1][4] <= i_wdata[4];
        regs[1][0] <= i_wdata[0];
        dly <= 2'h3;
        if (!i_wdata[0] && gap < GAP) bad <= 1'b1;
      end else if (i_wr && i_addr != 3'h5) begin
        regs[i_addr] <= i_wdata;
      end
      if (i_wr && i_addr == 3'h0) begin
        gap <= 16'h0;
        if (!i_wdata[1] && regs[1][1] && !regs[1][7] && !regs[1][5])
          bad <= 1'b1;
        if (!i_wdata[7] && regs[3][7] && !i_ext) bad <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cssw_pkg::*;
  // --------
  // Bench
  // --------
  logic       i_clk, i_nrst, i_wr, i_rd, ext, d_wr, d_rd;
  logic [1:0] i_addr;
  logic [2:0] d_addr;
  logic [7:0] i_wdata, o_rdata, rv, d_wdata, d_rdata;
  int         miscompares, n_tests;
  cssw_host #(.HIGH_SETTLE_CYC(5), .LOW_SETTLE_CYC(8), .POLL_LIMIT(20))
  u_dut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(1'b1), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_dev_addr(d_addr), .o_dev_wdata(d_wdata), .o_dev_wr(d_wr),
    .o_dev_rd(d_rd), .i_dev_rdata(d_rdata), .i_ext_clk_applied(ext)
  );
  cssw_dev_model #(.GAP(5)) u_dev (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(d_addr), .i_wdata(d_wdata),
    .i_wr(d_wr), .i_rd(d_rd), .i_ext(ext), .o_rdata(d_rdata)
  );
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Reset, one switch, then the device state and refusal of a second go
  task automatic run(input logic [7:0] cmd, src, clock_run_control, system_clock_select, clock_mode_setup, os, ks);
    int k;
    i_nrst <= 1'b0;
    ext <= 1'b0;
    repeat (3) @(posedge i_clk);
    i_nrst <= 1'b1;
    rd(REG_STATUS, rv);
    chk(rv, 8'h00);
    wr(REG_CMD, cmd);
    k = 0;
    rv = 8'h00;
    while (rv[STAT_DONE] !== 1'b1 && k < 300) begin
      if (k == 20) ext <= 1'b1;
      rd(REG_STATUS, rv);
      k++;
    end
    chk(rv, src | 8'h02);
    chk(u_dev.regs[0], clock_run_control);
    chk(u_dev.regs[1], system_clock_select);
    chk(u_dev.regs[2], ks);
    chk(u_dev.regs[3], clock_mode_setup);
    chk(u_dev.regs[4], os);
    chk({7'h0, u_dev.bad}, 8'h00);
    rd(REG_DEVSTAT, rv);
    chk(rv, system_clock_select);
    rd(REG_CMD, rv);
    chk(rv, cmd & 8'h7F);
    rd(2'h3, rv);
    chk(rv, 8'h00);
    wr(REG_CMD, cmd);
    rd(REG_STATUS, rv);
    chk(rv, src | 8'h06);
    wr(REG_STATUS, 8'h06);
    rd(REG_STATUS, rv);
    chk(rv, src);
    $display("test cmd %h done at %0t", cmd, $time);
  endtask
  initial begin
    #200000;
    miscompares++;
    stop_test();
  end
  initial begin
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 2'h0;
    i_wdata = 8'h00;
    ext = 1'b0;
    miscompares = 0;
    n_tests = 0;
    run(8'h80, 8'h10, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00);
    run(8'h81, 8'h20, 8'hC1, 8'hC3, 8'h00, 8'h00, 8'h01);
    run(8'h85, 8'h20, 8'hC1, 8'hC3, 8'h00, 8'h00, 8'h01);
    run(8'hAA, 8'h30, 8'h41, 8'h33, 8'h41, 8'h02, 8'h00);
    run(8'h83, 8'h40, 8'h41, 8'h33, 8'hC0, 8'h00, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
